// [verilog/dcev_pkg.sv]
`default_nettype none
package dcev_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_INT_CTRL  = 8'h00;
  localparam logic [7:0] OFF_SRC_ADDR  = 8'h04;
  localparam logic [7:0] OFF_CFG       = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0C;
  // Field positions in the interrupt control register
  localparam int FLAG_LSB = 0;
  localparam int EN_LSB   = 16;
  // Flag bit indices
  localparam int F_SRC_DONE = 7;
  localparam int F_SRC_HALF = 6;
  localparam int F_DST_DONE = 5;
  localparam int F_DST_HALF = 4;
  localparam int F_BLOCK    = 3;
  localparam int F_CELL     = 2;
  localparam int F_ABORT    = 1;
  localparam int F_ADDR_ERR = 0;
  // Config register fields
  localparam int CFG_AIRQ_LSB   = 8;
  localparam int CFG_ABORT_EN   = 0;
  localparam int CFG_PAT_EN     = 1;
  localparam int CFG_CHAN_ON    = 2;
  // Reset values
  localparam logic [7:0]  RST_FLAGS    = 8'h00;
  localparam logic [7:0]  RST_ENABLES  = 8'h00;
  localparam logic [31:0] RST_SRC_ADDR = 32'h0000_0000;
  localparam logic [7:0]  RST_AIRQ     = 8'hFF;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Events from the channel engine, one cycle pulses or levels
  typedef struct packed {
    logic [15:0] src_pointer;
    logic [15:0] src_size;
    logic [15:0] dst_pointer;
    logic [15:0] dst_size;
    logic        cell_done;
    logic        block_bytes_done;
    logic        pattern_match;
    logic        irq_valid;
    logic [7:0]  irq_number;
    logic        addr_err;
  } dcev_engine_t;
endpackage
`default_nettype wire

// [verilog/dcev_edge.sv]
`default_nettype none
// Rising-edge detector: pulses once when a condition becomes true
module dcev_edge (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic cond,
  output logic      rise
);
  logic prev;
  logic next_prev;

  // Remember last value
  always_comb begin
    next_prev = cond;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Start high so a condition already true at release gives no pulse
      prev <= 1'b1;
    end else begin
      prev <= next_prev;
    end
  end

  assign rise = cond & ~prev;
endmodule
`default_nettype wire

// [verilog/dcev_top.sv]
// Our own choices: register access over AXI4-Lite and the register offsets.
`default_nettype none
// Notes on behaviour
// - Enable bits 23..16: src done, src half, dst done, dst half, block, cell, abort, error.
// - Source done flag bit 7 sets when source pointer reaches source size.
// - Source half flag bit 6 sets when source pointer equals half source size.
// - Destination done flag bit 5 sets when destination pointer reaches its size.
// - Destination half flag bit 4 sets at half the destination size.
// - Block flag bit 3 sets on larger size transferred or pattern match.
// - Cell flag bit 2 sets each time a cell of bytes completes.
// - Abort flag bit 1 sets when matching abort interrupt aborts the transfer.
// - Address error flag bit 0 sets on invalid source or destination address.
// - Bits 31..24 and 15..8 of interrupt control read zero, ignore writes.
// - Source start address is a full 32-bit read/write register, resets zero.
// - Matched abort number with abort matching enabled aborts the transfer.
// - Pattern match with pattern abort enabled aborts and clears channel on.
module dcev_top (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire dcev_pkg::dcev_engine_t engine,
  output logic                       abort_req,
  output logic                       channel_on,
  output logic                       irq,
  output logic [31:0]                src_start_addr
);
  // Register state
  logic [7:0]  flags;
  logic [7:0]  enables;
  logic [7:0]  abort_irq_number;
  logic        abort_irq_en;
  logic        pattern_abort_en;
  logic [31:0] next_src_start_addr;
  logic [7:0]  next_flags;
  logic [7:0]  next_enables;
  logic [7:0]  next_abort_irq_number;
  logic        next_abort_irq_en;
  logic        next_pattern_abort_en;
  logic        next_channel_on;
  logic        next_abort_req;
  logic        next_irq;

  // Bus handshake state
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held;
  logic        next_w_held;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        wr_fire;
  logic        rd_fire;

  // Event conditions, edge detector outputs and hardware set terms
  logic [3:0]  ptr_cond;
  logic [3:0]  ptr_rise;
  logic        abort_hit;
  logic        pat_hit;
  logic [7:0]  hw_set;

  // Pointer comparisons, one pulse as the pointer arrives
  always_comb begin
    ptr_cond[3] = engine.src_pointer == engine.src_size;
    ptr_cond[2] = engine.src_pointer == {1'b0, engine.src_size[15:1]};
    ptr_cond[1] = engine.dst_pointer == engine.dst_size;
    ptr_cond[0] = engine.dst_pointer == {1'b0, engine.dst_size[15:1]};
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_edge
      dcev_edge u_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cond    (ptr_cond[gi]),
        .rise    (ptr_rise[gi])
      );
    end
  endgenerate

  // Hardware set terms for each flag
  always_comb begin
    abort_hit = engine.irq_valid && abort_irq_en &&
                (engine.irq_number == abort_irq_number);
    pat_hit   = engine.pattern_match;
    hw_set    = 8'h00;
    hw_set[dcev_pkg::F_SRC_DONE] = ptr_rise[3];
    hw_set[dcev_pkg::F_SRC_HALF] = ptr_rise[2];
    hw_set[dcev_pkg::F_DST_DONE] = ptr_rise[1];
    hw_set[dcev_pkg::F_DST_HALF] = ptr_rise[0];
    hw_set[dcev_pkg::F_BLOCK]    = engine.block_bytes_done | pat_hit;
    hw_set[dcev_pkg::F_CELL]     = engine.cell_done;
    hw_set[dcev_pkg::F_ABORT]    = abort_hit;
    hw_set[dcev_pkg::F_ADDR_ERR] = engine.addr_err;
  end

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Write path: capture address and data in either order, then commit
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      unique case (aw_addr)
        dcev_pkg::OFF_INT_CTRL, dcev_pkg::OFF_SRC_ADDR,
        dcev_pkg::OFF_CFG, dcev_pkg::OFF_STATUS: next_bresp = dcev_pkg::RESP_OKAY;
        default: next_bresp = dcev_pkg::RESP_SLVERR;
      endcase
    end
  end

  // Register updates; hardware set wins over a software clear
  always_comb begin
    next_flags            = flags;
    next_enables          = enables;
    next_src_start_addr   = src_start_addr;
    next_abort_irq_number = abort_irq_number;
    next_abort_irq_en     = abort_irq_en;
    next_pattern_abort_en = pattern_abort_en;
    next_channel_on       = channel_on;
    if (wr_fire) begin
      unique case (aw_addr)
        dcev_pkg::OFF_INT_CTRL: begin
          if (w_strb[0]) begin
            next_flags = w_data[dcev_pkg::FLAG_LSB +: 8];
          end
          if (w_strb[2]) begin
            next_enables = w_data[dcev_pkg::EN_LSB +: 8];
          end
        end
        dcev_pkg::OFF_SRC_ADDR: begin
          for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
              next_src_start_addr[8*b +: 8] = w_data[8*b +: 8];
            end
          end
        end
        dcev_pkg::OFF_CFG: begin
          if (w_strb[0]) begin
            next_abort_irq_en     = w_data[dcev_pkg::CFG_ABORT_EN];
            next_pattern_abort_en = w_data[dcev_pkg::CFG_PAT_EN];
            next_channel_on       = w_data[dcev_pkg::CFG_CHAN_ON];
          end
          if (w_strb[1]) begin
            next_abort_irq_number = w_data[dcev_pkg::CFG_AIRQ_LSB +: 8];
          end
        end
        default: begin
        end
      endcase
    end
    next_flags = next_flags | hw_set;
    if (pattern_abort_en && pat_hit) begin
      next_channel_on = 1'b0;
    end
    next_abort_req = abort_hit | (pattern_abort_en & pat_hit);
    next_irq       = |(next_flags & next_enables);
  end

  // Read path
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp  = dcev_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        dcev_pkg::OFF_INT_CTRL: next_rdata = {8'h00, enables, 8'h00, flags};
        dcev_pkg::OFF_SRC_ADDR: next_rdata = src_start_addr;
        dcev_pkg::OFF_CFG: next_rdata = {16'h0000, abort_irq_number, 5'h00,
                                         channel_on, pattern_abort_en, abort_irq_en};
        dcev_pkg::OFF_STATUS: next_rdata = {29'h0000_0000, abort_req, irq, channel_on};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = dcev_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // All state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags            <= dcev_pkg::RST_FLAGS;
      enables          <= dcev_pkg::RST_ENABLES;
      src_start_addr   <= dcev_pkg::RST_SRC_ADDR;
      abort_irq_number <= dcev_pkg::RST_AIRQ;
      abort_irq_en     <= 1'b0;
      pattern_abort_en <= 1'b0;
      channel_on       <= 1'b0;
      abort_req        <= 1'b0;
      irq              <= 1'b0;
      aw_held          <= 1'b0;
      w_held           <= 1'b0;
      aw_addr          <= 8'h00;
      w_data           <= 32'h0000_0000;
      w_strb           <= 4'h0;
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= dcev_pkg::RESP_OKAY;
      s_axi_rvalid     <= 1'b0;
      s_axi_rdata      <= 32'h0000_0000;
      s_axi_rresp      <= dcev_pkg::RESP_OKAY;
      s_axi_awready    <= 1'b0;
      s_axi_wready     <= 1'b0;
      s_axi_arready    <= 1'b0;
    end else begin
      flags            <= next_flags;
      enables          <= next_enables;
      src_start_addr   <= next_src_start_addr;
      abort_irq_number <= next_abort_irq_number;
      abort_irq_en     <= next_abort_irq_en;
      pattern_abort_en <= next_pattern_abort_en;
      channel_on       <= next_channel_on;
      abort_req        <= next_abort_req;
      irq              <= next_irq;
      aw_held          <= next_aw_held;
      w_held           <= next_w_held;
      aw_addr          <= next_aw_addr;
      w_data           <= next_w_data;
      w_strb           <= next_w_strb;
      s_axi_bvalid     <= next_bvalid;
      s_axi_bresp      <= next_bresp;
      s_axi_rvalid     <= next_rvalid;
      s_axi_rdata      <= next_rdata;
      s_axi_rresp      <= next_rresp;
      // Ready only while the slot is free
      s_axi_awready    <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready     <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready    <= !next_rvalid && !rd_fire;
    end
  end

  // Checks
  src_done_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ptr_rise[3] |=> flags[dcev_pkg::F_SRC_DONE])
    else $error("source done flag not set");
  src_half_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ptr_rise[2] |=> flags[dcev_pkg::F_SRC_HALF])
    else $error("source half flag not set");
  dst_done_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ptr_rise[1] |=> flags[dcev_pkg::F_DST_DONE])
    else $error("destination done flag not set");
  dst_half_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ptr_rise[0] |=> flags[dcev_pkg::F_DST_HALF])
    else $error("destination half flag not set");
  block_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (engine.block_bytes_done || engine.pattern_match) |=> flags[dcev_pkg::F_BLOCK])
    else $error("block flag not set");
  cell_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    engine.cell_done |=> flags[dcev_pkg::F_CELL])
    else $error("cell flag not set");
  abort_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    abort_hit |=> flags[dcev_pkg::F_ABORT] && abort_req)
    else $error("abort not taken");
  addr_err_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    engine.addr_err |=> flags[dcev_pkg::F_ADDR_ERR])
    else $error("address error flag not set");
  pat_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pattern_abort_en && engine.pattern_match) |=> !channel_on && abort_req)
    else $error("pattern abort failed");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(flags & enables))
    else $error("interrupt request mismatch");
  flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!wr_fire && $past(aresetn)) |=> (flags & $past(flags)) == $past(flags))
    else $error("flag lost without a write");
  set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && hw_set != 8'h00) |=> (flags & $past(hw_set)) == $past(hw_set))
    else $error("hardware set lost to a write");
  int_read_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_fire && s_axi_araddr == dcev_pkg::OFF_INT_CTRL) |=>
      s_axi_rdata[31:24] == 8'h00 && s_axi_rdata[15:8] == 8'h00)
    else $error("unimplemented bits read nonzero");
endmodule
`default_nettype wire

// [tb/dcev_engine_model.sv]
`default_nettype none
// Channel engine stand-in: walks the byte count and reports transfer events
module dcev_engine_model #(
  parameter int CELL = 4
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              go,
  input  wire logic              ev_pat,
  input  wire logic              ev_irq,
  input  wire logic [7:0]        ev_num,
  input  wire logic              ev_aerr,
  input  wire logic [15:0]       ssize,
  input  wire logic [15:0]       dsize,
  input  wire logic              abort_req,
  output dcev_pkg::dcev_engine_t engine,
  output logic                   busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt;
  logic [15:0] last;
  logic        step;
  assign last = (ssize > dsize) ? ssize : dsize;
  assign step = busy && !abort_req;
  // Byte counter; an abort request stops the walk at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      cnt  <= 16'h0000;
    end else if (go) begin
      busy <= 1'b1;
      cnt  <= 16'h0000;
    end else if (busy) begin
      busy <= !abort_req && (cnt + 16'h0001 != last);
      cnt  <= step ? cnt + 16'h0001 : cnt;
    end
  end
  // Pointers hold when idle; the irq number is scrambled while not offered
  always_comb begin
    engine.src_pointer      = (cnt < ssize) ? cnt : ssize;
    engine.src_size         = ssize;
    engine.dst_pointer      = (cnt < dsize) ? cnt : dsize;
    engine.dst_size         = dsize;
    engine.cell_done        = step && (((cnt + 16'h0001) % CELL) == 0);
    engine.block_bytes_done = step && (cnt + 16'h0001 == last);
    engine.pattern_match    = ev_pat;
    engine.irq_valid        = ev_irq;
    engine.irq_number       = ev_irq ? ev_num : ~ev_num;
    engine.addr_err         = ev_aerr;
  end
endmodule
`default_nettype wire

// [tb/dma_channel_irq_and_source_addr_tb.sv]
`default_nettype none
module dma_channel_irq_and_source_addr_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic go, ev_pat, ev_irq, ev_aerr, abort_req, channel_on, irq, busy;
  logic [7:0]  awaddr, araddr, ev_num;
  logic [31:0] wdata, rdata, ssa;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] ssize, dsize;
  dcev_pkg::dcev_engine_t eng;
  int failures = 0;
  int cmp_count = 0;
  int ab_cnt = 0;

  dcev_top i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .engine(eng), .abort_req(abort_req), .channel_on(channel_on), .irq(irq),
    .src_start_addr(ssa));

  dcev_engine_model #(.CELL(4)) i_eng (.aclk(aclk), .aresetn(aresetn), .go(go),
    .ev_pat(ev_pat), .ev_irq(ev_irq), .ev_num(ev_num), .ev_aerr(ev_aerr), .ssize(ssize),
    .dsize(dsize), .abort_req(abort_req), .engine(eng), .busy(busy));

  // Clock at 100 MHz
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Abort request pulse counter
  always @(posedge aclk) begin
    if (abort_req === 1'b1) ab_cnt <= ab_cnt + 1;
  end

  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus write: address and data offered together, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // One-cycle engine event: 0 pattern, 1 interrupt, 2 address error, 3 start
  task automatic pulse(input int k, input logic [7:0] n);
    ev_num <= n;
    case (k)
      0: ev_pat <= 1'b1;
      1: ev_irq <= 1'b1;
      2: ev_aerr <= 1'b1;
      default: go <= 1'b1;
    endcase
    @(posedge aclk);
    {go, ev_pat, ev_irq, ev_aerr} <= 4'h0;
    @(posedge aclk);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {go, ev_pat, ev_irq, ev_aerr} = 4'h0;
    {awaddr, araddr, ev_num, wdata, wstrb} = 60'h0;
    wstrb = 4'hF;
    // Zero sizes at reset: pointers already equal sizes at release
    ssize = 16'h0000;
    dsize = 16'h0000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(dcev_pkg::OFF_INT_CTRL, 32'h0, dcev_pkg::RESP_OKAY);
    rd(dcev_pkg::OFF_SRC_ADDR, 32'h0, dcev_pkg::RESP_OKAY);
    ssize <= 16'h0008;
    dsize <= 16'h000C;
    wr(dcev_pkg::OFF_SRC_ADDR, 32'hA5C3_F00F, dcev_pkg::RESP_OKAY);
    rd(dcev_pkg::OFF_SRC_ADDR, 32'hA5C3_F00F, dcev_pkg::RESP_OKAY);
    chk(ssa, 32'hA5C3_F00F);
    wr(dcev_pkg::OFF_INT_CTRL, 32'hFFFF_FF00, dcev_pkg::RESP_OKAY);
    rd(dcev_pkg::OFF_INT_CTRL, 32'h00FF_0000, dcev_pkg::RESP_OKAY);
    pulse(3, 8'h00);
    while (busy !== 1'b0) @(posedge aclk);
    repeat (2) @(posedge aclk);
    rd(dcev_pkg::OFF_INT_CTRL, 32'h00FF_00FC, dcev_pkg::RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    wr(dcev_pkg::OFF_INT_CTRL, 32'h00FF_0000, dcev_pkg::RESP_OKAY);
    rd(dcev_pkg::OFF_INT_CTRL, 32'h00FF_0000, dcev_pkg::RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(dcev_pkg::OFF_INT_CTRL, 32'h0, dcev_pkg::RESP_OKAY);
    pulse(2, 8'h00);
    rd(dcev_pkg::OFF_INT_CTRL, 32'h1, dcev_pkg::RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(dcev_pkg::OFF_INT_CTRL, 32'h0001_0001, dcev_pkg::RESP_OKAY);
    rd(dcev_pkg::OFF_STATUS, 32'h2, dcev_pkg::RESP_OKAY);
    wr(dcev_pkg::OFF_INT_CTRL, 32'h0, dcev_pkg::RESP_OKAY);
    wr(dcev_pkg::OFF_CFG, 32'h2A05, dcev_pkg::RESP_OKAY);
    chk({31'h0, channel_on}, 32'h1);
    pulse(1, 8'h2B);
    pulse(3, 8'h00);
    pulse(1, 8'h2A);
    repeat (3) @(posedge aclk);
    chk(ab_cnt, 32'h1);
    chk({31'h0, busy}, 32'h0);
    rd(dcev_pkg::OFF_INT_CTRL, 32'h2, dcev_pkg::RESP_OKAY);
    wr(dcev_pkg::OFF_INT_CTRL, 32'h0, dcev_pkg::RESP_OKAY);
    wr(dcev_pkg::OFF_CFG, 32'h2A07, dcev_pkg::RESP_OKAY);
    pulse(0, 8'h00);
    rd(dcev_pkg::OFF_INT_CTRL, 32'h8, dcev_pkg::RESP_OKAY);
    chk({31'h0, channel_on}, 32'h0);
    rd(dcev_pkg::OFF_CFG, 32'h2A03, dcev_pkg::RESP_OKAY);
    chk(ab_cnt, 32'h2);
    // Matching interrupt with abort matching off: no abort, no flag
    wr(dcev_pkg::OFF_CFG, 32'h2A00, dcev_pkg::RESP_OKAY);
    pulse(1, 8'h2A);
    rd(dcev_pkg::OFF_INT_CTRL, 32'h8, dcev_pkg::RESP_OKAY);
    chk(ab_cnt, 32'h2);
    // Event held across a clearing write: the hardware set wins
    ev_aerr <= 1'b1;
    wr(dcev_pkg::OFF_INT_CTRL, 32'h0, dcev_pkg::RESP_OKAY);
    ev_aerr <= 1'b0;
    rd(dcev_pkg::OFF_INT_CTRL, 32'h1, dcev_pkg::RESP_OKAY);
    // Reset in mid-run restores flags, enables and the start address
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(dcev_pkg::OFF_INT_CTRL, 32'h0, dcev_pkg::RESP_OKAY);
    rd(dcev_pkg::OFF_SRC_ADDR, 32'h0, dcev_pkg::RESP_OKAY);
    chk(ssa, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF, dcev_pkg::RESP_SLVERR);
    rd(8'h40, 32'h0, dcev_pkg::RESP_SLVERR);
    wrap_up();
  end
endmodule
`default_nettype wire
